/* verilog/pbdc_pkg.sv */
// Package with command codes, address offsets and carrier types for the bus command decoder.
package pbdc_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] PBDC_CMD_GTL = 8'h01;
    localparam logic [7:0] PBDC_CMD_TRG = 8'h08;
    localparam logic [7:0] PBDC_CMD_LLO = 8'h11;
    localparam logic [7:0] PBDC_CMD_DCL = 8'h14;
    localparam logic [7:0] PBDC_CMD_SDC = 8'h04;
    localparam logic [7:0] PBDC_CMD_UNL = 8'h3f;
    localparam logic [7:0] PBDC_CMD_UNT = 8'h5f;
    localparam logic [7:0] PBDC_LISTEN_BASE = 8'h20;
    localparam logic [7:0] PBDC_TALK_BASE = 8'h40;
    localparam logic [4:0] PBDC_ADDR_MAX = 5'h1e;
    localparam logic [2:0] PBDC_GROUP_LSB = 3'h5;

    typedef enum {
        PBDC_LOCAL,
        PBDC_REMOTE
    } pbdc_ctl_state_type;

    typedef struct packed {
        logic valid;
        logic atn;
        logic [7:0] data;
    } pbdc_byte_type;

    typedef struct packed {
        logic trigger;
        logic dev_clear;
    } pbdc_event_type;
endpackage

/* verilog/pbdc_device.sv */
// Device-side remote, lockout, addressing and service-request logic for a parallel instrument bus.
//
// Overview of operation
// R1 - Local state means front panel works; remote state means bus control.
// R2 - Remote control is accepted only while remote-enable is asserted.
// R3 - With remote-enable asserted, becoming a listener puts the device in remote.
// R4 - Front-panel local key returns to local unless locked out.
// R5 - Only the system controller drives remote-enable.
// R6 - System controller asserts remote-enable after power-up and holds it.
// R7 - Local lockout command disables the local key for all devices.
// R8 - Go-to-local returns addressed listeners to local state.
// R9 - Trigger starts the device action in addressed listeners.
// R10 - Device clear resets every device regardless of addressing.
// R11 - Selected device clear resets only addressed listeners.
// R12 - Controller sends untalk, unlisten, talk, listens, data, then cleans up.
// R13 - Listen address is 32 plus bus address; talk is 64 plus.
// R14 - Controller reads by untalk, unlisten, talk source, own listen, data.
// R15 - Raise a service request on task completion or error condition.
// R16 - Unlisten drops listener state until own listen address returns.
// R17 - Bytes are commands only while attention is asserted.
// R18 - Valid bus addresses are 0 through 30.
// R19 - Another device's talk address makes this device leave talker state.
// R20 - Releasing remote-enable clears remote, lockout and addressing.
module pbdc_device
    import pbdc_pkg::*;
#(
    parameter bit LOCKOUT_SUPPORT = 1'b1
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire pbdc_byte_type bus_byte_in,
    input wire logic ren_in,
    input wire logic [4:0] bus_addr_in,
    input wire logic local_key_in,
    input wire logic task_done_in,
    input wire logic error_in,
    input wire logic srq_ack_in,
    output logic remote_out,
    output logic lockout_out,
    output logic listener_out,
    output logic talker_out,
    output logic data_valid_out,
    output logic [7:0] data_out,
    output pbdc_event_type event_out,
    output logic srq_out
);

    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // State and output registers with their next values.

    pbdc_ctl_state_type state_reg;
    pbdc_ctl_state_type state_next;
    logic lockout_reg;
    logic lockout_next;
    logic listener_reg;
    logic listener_next;
    logic talker_reg;
    logic talker_next;
    logic srq_reg;
    logic srq_next;
    logic data_valid_reg;
    logic data_valid_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    pbdc_event_type event_reg;
    pbdc_event_type event_next;

    ////////////////////////////////////////////////////////////////////////////
    // Fields of the incoming byte.

    wire logic byte_valid;
    wire logic byte_atn;
    wire logic [7:0] byte_data;
    wire logic [7:0] cmd;

    assign byte_valid = bus_byte_in.valid;
    assign byte_atn = bus_byte_in.atn;
    assign byte_data = bus_byte_in.data;
    // Bit 7 is not part of the command set, so it is masked before any compare.
    assign cmd = {1'h0, byte_data[6:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Qualification of commands and data bytes.

    wire logic cmd_take;
    wire logic data_take;

    assign cmd_take = byte_valid && byte_atn && ren_in; // [R17] [R2]
    assign data_take = byte_valid && !byte_atn && listener_reg; // [R17]

    ////////////////////////////////////////////////////////////////////////////
    // Own address decoding.

    wire logic addr_ok;
    wire logic [7:0] my_listen;
    wire logic [7:0] my_talk;

    assign addr_ok = bus_addr_in <= PBDC_ADDR_MAX; // [R18]
    assign my_listen = PBDC_LISTEN_BASE + {3'h0, bus_addr_in}; // [R13]
    assign my_talk = PBDC_TALK_BASE + {3'h0, bus_addr_in}; // [R13]

    ////////////////////////////////////////////////////////////////////////////
    // Command codes, before qualification.

    wire logic is_my_listen;
    wire logic is_my_talk;
    wire logic is_talk_grp;
    wire logic is_unl;
    wire logic is_unt;
    wire logic is_llo;
    wire logic is_gtl;
    wire logic is_trg;
    wire logic is_dcl;
    wire logic is_sdc;

    assign is_my_listen = addr_ok && cmd == my_listen; // [R13] [R18]
    assign is_my_talk = addr_ok && cmd == my_talk; // [R13] [R18]
    assign is_talk_grp = cmd[6:PBDC_GROUP_LSB] == 2'h2;
    assign is_unl = cmd == PBDC_CMD_UNL;
    assign is_unt = cmd == PBDC_CMD_UNT;
    assign is_llo = cmd == PBDC_CMD_LLO;
    assign is_gtl = cmd == PBDC_CMD_GTL;
    assign is_trg = cmd == PBDC_CMD_TRG;
    assign is_dcl = cmd == PBDC_CMD_DCL;
    assign is_sdc = cmd == PBDC_CMD_SDC;

    ////////////////////////////////////////////////////////////////////////////
    // Qualified command hits.

    wire logic hit_mla;
    wire logic hit_mta;
    wire logic hit_unl;
    wire logic hit_unt;
    wire logic hit_other_talk;
    wire logic hit_llo;
    wire logic hit_gtl;
    wire logic hit_trg;
    wire logic hit_dcl;
    wire logic hit_sdc;
    wire logic key_return;

    assign hit_mla = cmd_take && is_my_listen; // [R3]
    assign hit_mta = cmd_take && is_my_talk; // [R13]
    assign hit_unl = cmd_take && is_unl; // [R16]
    assign hit_unt = cmd_take && is_unt; // [R19]
    assign hit_other_talk = cmd_take && is_talk_grp && !is_unt && !is_my_talk; // [R19]
    // Without lockout support the command stays legal on the bus but has no effect here.
    assign hit_llo = cmd_take && is_llo && LOCKOUT_SUPPORT; // [R7]
    assign hit_gtl = cmd_take && is_gtl && listener_reg; // [R8]
    assign hit_trg = cmd_take && is_trg && listener_reg; // [R9]
    assign hit_dcl = cmd_take && is_dcl; // [R10]
    assign hit_sdc = cmd_take && is_sdc && listener_reg; // [R11]
    assign key_return = local_key_in && !lockout_reg; // [R4]

    ////////////////////////////////////////////////////////////////////////////
    // Remote and local state.

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PBDC_LOCAL: begin
                if (hit_mla) begin
                    state_next = PBDC_REMOTE; // [R3] [R1]
                end
            end
            PBDC_REMOTE: begin
                if (hit_gtl || key_return) begin
                    state_next = PBDC_LOCAL; // [R8] [R4] [R1]
                end
            end
            default: begin
                state_next = PBDC_LOCAL;
            end
        endcase
        // Dropping remote-enable overrides anything decoded in the same cycle.
        if (!ren_in) begin
            state_next = PBDC_LOCAL; // [R20] [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lockout and addressed flags.

    always_comb begin
        lockout_next = lockout_reg;
        if (hit_llo) begin
            lockout_next = 1'h1; // [R7]
        end
        if (!ren_in) begin
            lockout_next = 1'h0; // [R20]
        end
    end

    always_comb begin
        listener_next = listener_reg;
        if (hit_unl) begin
            listener_next = 1'h0; // [R16]
        end
        if (hit_mla) begin
            listener_next = 1'h1; // [R16]
        end
        if (!ren_in) begin
            listener_next = 1'h0; // [R20]
        end
    end

    always_comb begin
        talker_next = talker_reg;
        if (hit_unt || hit_other_talk) begin
            talker_next = 1'h0; // [R19]
        end
        if (hit_mta) begin
            talker_next = 1'h1; // [R13]
        end
        if (!ren_in) begin
            talker_next = 1'h0; // [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events, service request and received data.

    always_comb begin
        event_next = '0;
        event_next.trigger = hit_trg; // [R9]
        // Both clears ask for the same device reset, so they share one pulse.
        event_next.dev_clear = hit_dcl || hit_sdc; // [R10] [R11]
    end

    always_comb begin
        // A new cause sets the request in the same cycle an acknowledge arrives.
        srq_next = srq_reg;
        if (srq_ack_in) begin
            srq_next = 1'h0;
        end
        if (task_done_in || error_in) begin
            srq_next = 1'h1; // [R15]
        end
    end

    // Data bytes are only passed while listening; the link has no buffer of its own.
    always_comb begin
        data_valid_next = data_take; // [R17]
        data_next = data_reg;
        if (data_take) begin
            data_next = byte_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_reg <= PBDC_LOCAL;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            lockout_reg <= 1'h0;
        end else begin
            lockout_reg <= lockout_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            listener_reg <= 1'h0;
        end else begin
            listener_reg <= listener_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            talker_reg <= 1'h0;
        end else begin
            talker_reg <= talker_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            event_reg <= '0;
        end else begin
            event_reg <= event_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            srq_reg <= 1'h0;
        end else begin
            srq_reg <= srq_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            data_valid_reg <= 1'h0;
        end else begin
            data_valid_reg <= data_valid_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            data_reg <= 8'h00;
        end else begin
            data_reg <= data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign remote_out = state_reg == PBDC_REMOTE;
    assign lockout_out = lockout_reg;
    assign listener_out = listener_reg;
    assign talker_out = talker_reg;
    assign data_valid_out = data_valid_reg;
    assign data_out = data_reg;
    assign event_out = event_reg;
    assign srq_out = srq_reg;

endmodule

/* verification/pbdc_ctl_model.sv */
// Controller model that drives command and data bytes and the remote-enable line.
module pbdc_ctl_model import pbdc_pkg::*; (
    input wire logic ref_clk_in,
    output pbdc_byte_type bus_byte_out,
    output logic ren_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial ren_out = 1'h1;
    initial bus_byte_out = '0;
    // A released bus shows the inverse of the last byte, so stale data never looks valid.
    task automatic put(input logic atn, input logic [7:0] data);
        @(posedge ref_clk_in);
        bus_byte_out <= '{1'h1, atn, data};
        @(posedge ref_clk_in);
        bus_byte_out <= '{1'h0, ~atn, ~data};
    endtask
    task automatic set_ren(input logic v);
        @(posedge ref_clk_in);
        ren_out <= v;
        @(posedge ref_clk_in);
    endtask
endmodule

/* verification/pbdc_assertions.sv */
// Assertion checker for the bus command device block.
module pbdc_assertions import pbdc_pkg::*; #(parameter bit LOCKOUT_SUPPORT = 1'b1) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire pbdc_byte_type bus_byte_in,
    input wire logic ren_in,
    input wire logic [4:0] bus_addr_in,
    input wire logic task_done_in,
    input wire logic remote_out,
    input wire logic lockout_out,
    input wire logic listener_out,
    input wire logic data_valid_out,
    input wire logic [7:0] data_out,
    input wire pbdc_event_type event_out,
    input wire logic srq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic cmd = bus_byte_in.valid && bus_byte_in.atn && ren_in;
    wire logic [6:0] c = bus_byte_in.data[6:0];
    property p_ren; !ren_in |=> !remote_out && !lockout_out && !listener_out; endproperty
    a_ren: assert property (p_ren) else $error("ren release");
    property p_lsn; cmd && c == {2'h1, bus_addr_in} && bus_addr_in != 5'h1f |=> listener_out && remote_out; endproperty
    a_lsn: assert property (p_lsn) else $error("listen address");
    property p_unl; cmd && c == 7'h3f |=> !listener_out; endproperty
    a_unl: assert property (p_unl) else $error("unlisten");
    property p_llo; cmd && c == 7'h11 |=> lockout_out == LOCKOUT_SUPPORT; endproperty
    a_llo: assert property (p_llo) else $error("lockout");
    property p_trg; cmd && c == 7'h08 |=> event_out.trigger == $past(listener_out); endproperty
    a_trg: assert property (p_trg) else $error("trigger");
    property p_dcl; cmd && c == 7'h14 |=> event_out.dev_clear; endproperty
    a_dcl: assert property (p_dcl) else $error("device clear");
    property p_dat; bus_byte_in.valid && !bus_byte_in.atn |=> data_valid_out == $past(listener_out)
        && (!data_valid_out || data_out == $past(bus_byte_in.data)); endproperty
    a_dat: assert property (p_dat) else $error("data byte");
    property p_srq; task_done_in |=> srq_out; endproperty
    a_srq: assert property (p_srq) else $error("service request");
endmodule
////////////////////////////////////////////////////////////////
bind pbdc_device pbdc_assertions #(.LOCKOUT_SUPPORT(LOCKOUT_SUPPORT)) chk_i (.ref_clk_in, .rstn_in, .bus_byte_in,
    .ren_in, .bus_addr_in, .task_done_in, .remote_out, .lockout_out, .listener_out, .data_valid_out, .data_out,
    .event_out, .srq_out);

/* verification/pbdc_device_tb.sv */
// Self-checking bench for the bus command device block.
module pbdc_device_tb import pbdc_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 1'h0;
    logic rstn_in = 1'h0;
    logic [3:0] ui = 4'h0;
    logic [4:0] addr = 5'h05;
    pbdc_byte_type bus_byte;
    pbdc_event_type ev;
    logic ren, remote, lockout, listener, talker, dv, srq;
    logic [7:0] dout;
    logic [31:0] s;
    int num_errors = 0;
    int comparisons = 0;
    wire logic [7:0] obs = {srq, ev, talker, listener, lockout, remote, dv};
    // Step word: op, byte, flag mask, expected flags; ops 2 to 5 pulse key, done, error, ack.
    // Op 7 moves the own address to the top of the valid range.
    localparam logic [31:0] steps [0:29] = '{32'h005f1000, 32'h00401000, 32'h003f0800,
        32'h00250a0a, 32'h00084040, 32'h015a0101, 32'h02000200, 32'h00250202,
        32'h00110404, 32'h02000202, 32'h003f0800, 32'h00010202, 32'h00084000,
        32'h01330100, 32'h00260800, 32'h00250808, 32'h00042020, 32'h00010200,
        32'h003f0800, 32'h00042000, 32'h00142020, 32'h00451010, 32'h00461000,
        32'h03008080, 32'h05008000, 32'h04008080, 32'h071e8080, 32'h003e0a0a,
        32'h06000e00, 32'h003e0a00};
    always #2.5 ref_clk_in = ~ref_clk_in;
    pbdc_ctl_model ctl (.ref_clk_in(ref_clk_in), .bus_byte_out(bus_byte), .ren_out(ren));
    pbdc_device dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus_byte_in(bus_byte), .ren_in(ren),
        .bus_addr_in(addr), .local_key_in(ui[0]), .task_done_in(ui[1]), .error_in(ui[2]), .srq_ack_in(ui[3]),
        .remote_out(remote), .lockout_out(lockout), .listener_out(listener), .talker_out(talker),
        .data_valid_out(dv), .data_out(dout), .event_out(ev), .srq_out(srq));
    task automatic pulse(input logic [3:0] i);
        @(posedge ref_clk_in);
        ui[i] <= 1'h1;
        @(posedge ref_clk_in);
        ui[i] <= 1'h0;
        @(posedge ref_clk_in);
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        for (int i = 0; i < 30; i++) begin
            s = steps[i];
            case (s[27:24])
                4'h0: ctl.put(1'h1, s[23:16]);
                4'h1: ctl.put(1'h0, s[23:16]);
                4'h6: ctl.set_ren(1'h0);
                4'h7: begin
                    @(posedge ref_clk_in);
                    addr <= s[20:16];
                end
                default: pulse(s[27:24] - 4'h2);
            endcase
            // Outputs are registered, so sample after the edge's updates have landed.
            #1;
            comparisons++;
            if ((obs & s[15:8]) !== s[7:0] || (s[27:24] == 4'h1 && s[0] && dout !== s[23:16])) begin
                $display("[FAIL] %0t step %0d flags %h", $time, i, obs);
                num_errors++;
            end
        end
        print_verdict();
    end
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
endmodule
